// ==== logic/waveform_sequencer_dds.sv ====
// Purpose: Segment playback sequencer and phase-lookup synthesizer with APB registers
// Assumes: 250 MHz sys_clk, converter update at 40 MHz, pins synchronous to sys_clk
// Notes:   Memories are loaded over APB; generation needs no bus traffic
//
// Functional notes
// - New converter sample every update at 40 MHz, fed from local memory.
// - Playback memory holds 2,000,000 sixteen-bit words loaded before generation.
// - Segments at least 256 samples, multiple of 8, at most memory depth.
// - Entries play in listed order, loop up to 65,535, up to 290 entries.
// - One marker output pulse associated with each segment.
// - Sixteen-bit pattern follows waveform, with a clock for latching.
// - 32-bit phase accumulator upper bits address a 16,384-entry lookup.
// - Lookup memory is used only in synthesis mode, never by playback.
// - Changing the increment keeps accumulated phase, no discontinuity.
// - Accumulator wraps past lookup end back to the first entry.
// - Square follower tracks sine with host-adjustable duty while running.
// - Synthesis mode has no linking or looping, only simple triggering.
// - Switchable half-band interpolator producing 80 MSPS.
// - Single plays list once; continuous repeats forever after start.
// - Stepped plays one entry per trigger, wrapping after the last.
// - Burst repeats entry until trigger, finishes it, advances, wraps.
`timescale 1ns/10ps
`include "wfm_consts.svh"
module waveform_sequencer_dds (
   input wire logic sys_clk,           // System clock
   input wire logic reset_n,           // Asynchronous reset
   input wire logic psel,              // APB select
   input wire logic penable,           // APB access phase
   input wire logic pwrite,            // APB write
   input wire logic [7:0] paddr,       // APB byte address
   input wire logic [31:0] pwdata,     // APB write data
   output logic [31:0] prdata,         // APB read data
   output logic pready,                // APB ready
   output logic pslverr,               // APB error
   input wire logic ext_trig,          // External trigger level
   output logic [15:0] dac_data,       // Converter word
   output logic [15:0] pattern_out,    // Digital pattern word
   output logic pattern_clk,           // Pattern latch clock
   output logic marker_out,            // Segment marker
   output logic sync_out               // Square follower
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [15:0] wave_mem [`WAVE_DEPTH];
   logic [15:0] lut_mem [`LUT_DEPTH];
   wfm_pkg::wave_addr_t seq_start [`SEQ_DEPTH];
   wfm_pkg::wave_addr_t seq_len [`SEQ_DEPTH];
   logic [15:0] seq_loop [`SEQ_DEPTH];
   logic seq_mark [`SEQ_DEPTH];

   logic [4:0] ctrl_ff;
   logic [31:0] inc_ff;
   logic [15:0] duty_ff;
   wfm_pkg::wave_addr_t waddr_ff;
   logic [13:0] laddr_ff;
   wfm_pkg::seq_idx_t sidx_ff;
   wfm_pkg::seq_idx_t scnt_ff;
   wfm_pkg::wave_addr_t sstart_ff;
   wfm_pkg::wave_addr_t slen_ff;
   logic err_ff;
   logic [31:0] prdata_ff;

   wfm_pkg::seq_state_e state_ff;
   wfm_pkg::wave_addr_t addr_ff;
   wfm_pkg::wave_addr_t left_ff;
   logic [15:0] loops_ff;
   wfm_pkg::seq_idx_t ent_ff;
   logic first_ff;
   logic [31:0] phase_ff;
   logic trig_seen_ff;
   logic ext_d_ff;

   logic rd_pend_ff;
   logic [15:0] rd_data_ff;
   logic rd_mark_ff;

   logic [7:0] tick_acc_ff;
   logic tick_phase_ff;
   logic [15:0] pat_ff;
   logic pclk_ff;
   logic mark_ff;
   logic sync_ff;

   logic wr_en;
   logic rd_setup;
   logic trig;
   logic issue;
   logic seg_ok;
   logic last_ent;
   wfm_pkg::seq_idx_t next_ent;
   wfm_pkg::op_mode_e op_mode;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [16:0] buf_out_data;
   logic upd_tick;
   logic half_tick;
   logic step_tick;
   logic pop;
   logic [8:0] tick_sum;

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   // Offset compare shared by write, read and error decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // Mapped offsets; anything else answers with an error
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `OFF_SEQ_CNT);
   endfunction

   // Zero wait states; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped(paddr);
   assign prdata = prdata_ff;
   assign wr_en = psel & penable & pwrite & mapped(paddr);
   assign rd_setup = psel & ~penable & ~pwrite;
   assign op_mode = wfm_pkg::op_mode_e'(ctrl_ff[`CTRL_OP_HI:`CTRL_OP_LO]);
   assign trig = (wr_en && hit(paddr, `OFF_TRIG) && pwdata[`TRIG_FIRE]) || (ext_trig && !ext_d_ff);
   // Entry must be long enough, aligned and inside memory
   assign seg_ok = (slen_ff >= 21'(`SEG_MIN)) && (slen_ff[2:0] == 3'h0)
                   && ({1'b0, sstart_ff} + {1'b0, slen_ff} <= 22'(`WAVE_DEPTH));

   // Control registers; increment and duty may change while running
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= `CTRL_RST;
         inc_ff <= `PHASE_INC_RST;
         duty_ff <= `DUTY_RST;
         scnt_ff <= 9'h000;
         sidx_ff <= 9'h000;
         sstart_ff <= 21'h000000;
         slen_ff <= 21'h000000;
      end else if (wr_en) begin
         if (hit(paddr, `OFF_CTRL)) ctrl_ff <= pwdata[4:0];
         if (hit(paddr, `OFF_PHASE_INC)) inc_ff <= pwdata;
         if (hit(paddr, `OFF_DUTY)) duty_ff <= pwdata[15:0];
         if (hit(paddr, `OFF_SEQ_CNT)) scnt_ff <= pwdata[8:0];
         if (hit(paddr, `OFF_SEQ_IDX)) sidx_ff <= pwdata[8:0];
         if (hit(paddr, `OFF_SEQ_START)) sstart_ff <= pwdata[20:0];
         if (hit(paddr, `OFF_SEQ_LEN)) slen_ff <= pwdata[20:0];
      end
   end

   // Load pointers auto-increment after each data write
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         waddr_ff <= 21'h000000;
         laddr_ff <= 14'h0000;
      end else if (wr_en) begin
         if (hit(paddr, `OFF_WADDR)) waddr_ff <= pwdata[20:0];
         else if (hit(paddr, `OFF_WDATA)) waddr_ff <= waddr_ff + 21'h000001;
         if (hit(paddr, `OFF_LADDR)) laddr_ff <= pwdata[13:0];
         else if (hit(paddr, `OFF_LDATA)) laddr_ff <= laddr_ff + 14'h0001;
      end
   end

   // Memory loads; loop write commits a whole sequence entry
   always_ff @(posedge sys_clk) begin
      if (wr_en && hit(paddr, `OFF_WDATA) && waddr_ff < 21'(`WAVE_DEPTH)) begin
         wave_mem[waddr_ff] <= pwdata[15:0];
      end
      if (wr_en && hit(paddr, `OFF_LDATA)) lut_mem[laddr_ff] <= pwdata[15:0];
      if (wr_en && hit(paddr, `OFF_SEQ_LOOP) && seg_ok && sidx_ff < 9'(`SEQ_DEPTH)) begin
         seq_start[sidx_ff] <= sstart_ff;
         seq_len[sidx_ff] <= slen_ff;
         seq_loop[sidx_ff] <= pwdata[15:0];
         seq_mark[sidx_ff] <= pwdata[`LOOP_MARK];
      end
   end

   // Rejected entry flag; a new rejection wins over a clear
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         err_ff <= 1'b0;
      end else if (wr_en && hit(paddr, `OFF_SEQ_LOOP) && (!seg_ok || sidx_ff >= 9'(`SEQ_DEPTH))) begin
         err_ff <= 1'b1;
      end else if (wr_en && hit(paddr, `OFF_TRIG) && pwdata[`TRIG_CLR_ERR]) begin
         err_ff <= 1'b0;
      end
   end

   // Read mux, captured one cycle ahead of the access phase
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_ff <= 32'h0000_0000;
         if (hit(paddr, `OFF_CTRL)) prdata_ff <= {27'h0, ctrl_ff};
         if (hit(paddr, `OFF_STATUS)) begin
            prdata_ff <= {16'h0, ent_ff, 3'h0, buf_out_valid, err_ff,
                          state_ff == wfm_pkg::st_wait, state_ff != wfm_pkg::st_idle};
         end
         if (hit(paddr, `OFF_PHASE_INC)) prdata_ff <= inc_ff;
         if (hit(paddr, `OFF_DUTY)) prdata_ff <= {16'h0, duty_ff};
         if (hit(paddr, `OFF_WADDR)) prdata_ff <= {11'h0, waddr_ff};
         if (hit(paddr, `OFF_LADDR)) prdata_ff <= {18'h0, laddr_ff};
         if (hit(paddr, `OFF_SEQ_IDX)) prdata_ff <= {23'h0, sidx_ff};
         if (hit(paddr, `OFF_SEQ_CNT)) prdata_ff <= {23'h0, scnt_ff};
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // One memory read in flight at a time keeps the buffer from overrunning
   assign issue = (state_ff == wfm_pkg::st_play) && buf_in_ready && !rd_pend_ff;
   assign last_ent = (ent_ff + 9'h001 >= scnt_ff);
   assign next_ent = last_ent ? 9'h000 : ent_ff + 9'h001;

   // Edge detect on the external trigger line
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) ext_d_ff <= 1'b0;
      else ext_d_ff <= ext_trig;
   end

   // Burst trigger is remembered until the current entry finishes; one arriving in the finishing cycle is kept into the next entry
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         trig_seen_ff <= 1'b0;
      end else if (trig && state_ff == wfm_pkg::st_play) begin
         trig_seen_ff <= 1'b1;
      end else if (state_ff != wfm_pkg::st_play || (issue && left_ff == 21'h000001 && loops_ff <= 16'h0001)) begin
         trig_seen_ff <= 1'b0;
      end
   end

   // Playback walk through entries, loops and samples
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= wfm_pkg::st_idle;
         addr_ff <= 21'h000000;
         left_ff <= 21'h000000;
         loops_ff <= 16'h0000;
         ent_ff <= 9'h000;
         first_ff <= 1'b0;
      end else if (!ctrl_ff[`CTRL_RUN]) begin
         state_ff <= wfm_pkg::st_idle;
      end else begin
         case (state_ff)
            wfm_pkg::st_idle: begin
               if (trig && ctrl_ff[`CTRL_SYNTH]) begin
                  state_ff <= wfm_pkg::st_play;
               end else if (trig && scnt_ff != 9'h000) begin
                  state_ff <= wfm_pkg::st_play;
                  ent_ff <= 9'h000;
                  addr_ff <= seq_start[0];
                  left_ff <= seq_len[0];
                  loops_ff <= seq_loop[0];
                  first_ff <= 1'b1;
               end
            end
            wfm_pkg::st_play: begin
               if (issue && !ctrl_ff[`CTRL_SYNTH]) begin
                  first_ff <= 1'b0;
                  if (left_ff != 21'h000001) begin
                     addr_ff <= addr_ff + 21'h000001;
                     left_ff <= left_ff - 21'h000001;
                  end else if (loops_ff > 16'h0001) begin
                     addr_ff <= seq_start[ent_ff];
                     left_ff <= seq_len[ent_ff];
                     loops_ff <= loops_ff - 16'h0001;
                  end else begin
                     // Entry done: pick the next one in this same cycle
                     first_ff <= 1'b1;
                     if (op_mode == wfm_pkg::op_burst && !trig_seen_ff && !trig) begin
                        addr_ff <= seq_start[ent_ff];
                        left_ff <= seq_len[ent_ff];
                        loops_ff <= seq_loop[ent_ff];
                     end else begin
                        ent_ff <= next_ent;
                        addr_ff <= seq_start[next_ent];
                        left_ff <= seq_len[next_ent];
                        loops_ff <= seq_loop[next_ent];
                     end
                     if (op_mode == wfm_pkg::op_single && last_ent) state_ff <= wfm_pkg::st_idle;
                     if (op_mode == wfm_pkg::op_stepped) state_ff <= wfm_pkg::st_wait;
                  end
               end
            end
            wfm_pkg::st_wait: begin
               if (trig) state_ff <= wfm_pkg::st_play;
            end
            default: state_ff <= wfm_pkg::st_idle;
         endcase
      end
   end

   // Phase accumulates without reset so increment changes stay continuous
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) phase_ff <= 32'h0000_0000;
      else if (issue && ctrl_ff[`CTRL_SYNTH]) phase_ff <= phase_ff + inc_ff;
   end

   // Sample fetch; lookup is touched only in synthesis mode
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_pend_ff <= 1'b0;
         rd_mark_ff <= 1'b0;
      end else begin
         rd_pend_ff <= issue;
         rd_mark_ff <= issue && !ctrl_ff[`CTRL_SYNTH] && first_ff && seq_mark[ent_ff];
      end
   end

   // Memory read ports
   always_ff @(posedge sys_clk) begin
      if (issue && ctrl_ff[`CTRL_SYNTH]) rd_data_ff <= lut_mem[phase_ff[31:18]];
      else if (issue) rd_data_ff <= wave_mem[addr_ff];
   end

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   two_entry_buf #(.W(17)) u_buf (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(rd_pend_ff),
      .in_ready(buf_in_ready),
      .in_data({rd_mark_ff, rd_data_ff}),
      .out_valid(buf_out_valid),
      .out_ready(upd_tick),
      .out_data(buf_out_data)
   );

   // Fractional divider gives exact 80 MHz steps; even steps are updates
   assign tick_sum = {1'b0, tick_acc_ff} + 9'(`INTERP_MHZ);
   assign step_tick = (tick_sum >= 9'(`CLK_MHZ));
   assign upd_tick = step_tick && !tick_phase_ff;
   assign half_tick = step_tick && tick_phase_ff;
   assign pop = upd_tick && buf_out_valid;

   // Update and half-update strobes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_acc_ff <= 8'h00;
         tick_phase_ff <= 1'b0;
      end else begin
         tick_acc_ff <= step_tick ? 8'(tick_sum - 9'(`CLK_MHZ)) : tick_sum[7:0];
         if (step_tick) tick_phase_ff <= ~tick_phase_ff;
      end
   end

   // Pattern, marker and follower change together with each update
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pat_ff <= 16'h0000;
         pclk_ff <= 1'b0;
         mark_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else if (pop) begin
         pat_ff <= buf_out_data[15:0];
         pclk_ff <= 1'b0;
         mark_ff <= buf_out_data[16];
         sync_ff <= ctrl_ff[`CTRL_SYNTH] && ($signed(buf_out_data[15:0]) > $signed(duty_ff));
      end else if (half_tick) begin
         pclk_ff <= 1'b1;
      end
   end

   halfband_interp u_interp (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .enable(ctrl_ff[`CTRL_FILT]),
      .take(pop),
      .half(half_tick),
      .smp_in(buf_out_data[15:0]),
      .smp_out(dac_data)
   );

   assign pattern_out = pat_ff;
   assign pattern_clk = pclk_ff;
   assign marker_out = mark_ff;
   assign sync_out = sync_ff;
endmodule

// ==== shared/wfm_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing figures of the waveform sequencer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef WFM_CONSTS_SVH
`define WFM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL      8'h00
`define OFF_TRIG      8'h04
`define OFF_STATUS    8'h08
`define OFF_PHASE_INC 8'h0c
`define OFF_DUTY      8'h10
`define OFF_WADDR     8'h14
`define OFF_WDATA     8'h18
`define OFF_LADDR     8'h1c
`define OFF_LDATA     8'h20
`define OFF_SEQ_IDX   8'h24
`define OFF_SEQ_START 8'h28
`define OFF_SEQ_LEN   8'h2c
`define OFF_SEQ_LOOP  8'h30
`define OFF_SEQ_CNT   8'h34

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_RUN      0
`define CTRL_SYNTH    1
`define CTRL_OP_LO    2
`define CTRL_OP_HI    3
`define CTRL_FILT     4
`define TRIG_FIRE     0
`define TRIG_CLR_ERR  1
`define LOOP_MARK     16

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define WAVE_DEPTH    2000000
`define LUT_DEPTH     16384
`define SEQ_DEPTH     290
`define SEG_MIN       256
`define SEG_ALIGN     8
`define CTRL_RST      5'h00
`define DUTY_RST      16'h0000
`define PHASE_INC_RST 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ       250
`define UPD_MHZ       40
`define INTERP_MHZ    (2 * `UPD_MHZ)

`endif

// ==== shared/wfm_pkg.sv ====
// Purpose: Types shared by the waveform sequencer files
// Assumes: Nothing beyond the constants header
// Notes:   Enum codes are left to the tool except where a field value is cast
package wfm_pkg;
   // Sequence operating modes, order matches the control field
   typedef enum logic [1:0] {op_single, op_continuous, op_stepped, op_burst} op_mode_e;
   // Sequencer states
   typedef enum {st_idle, st_play, st_wait} seq_state_e;
   typedef logic [20:0] wave_addr_t;
   typedef logic [8:0] seq_idx_t;
endpackage

// ==== logic/two_entry_buf.sv ====
// Purpose: Two-entry valid/ready buffer in the sample path
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Full and empty are exact; in_ready drops when both entries hold data
`timescale 1ns/10ps
module two_entry_buf #(
   parameter int W = 17
) (
   input wire logic sys_clk,           // System clock
   input wire logic reset_n,           // Asynchronous reset
   input wire logic in_valid,          // Word offered
   output logic in_ready,              // Room for a word
   input wire logic [W-1:0] in_data,   // Word in
   output logic out_valid,             // Word available
   input wire logic out_ready,         // Consumer takes word
   output logic [W-1:0] out_data       // Oldest word
);
   logic [W-1:0] ent_ff [2];
   logic [1:0] cnt_ff;
   logic rd_ptr_ff;
   logic wr_ptr_ff;
   logic push;
   logic pop;

   // Handshake terms
   assign in_ready = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data = ent_ff[rd_ptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Occupancy and pointers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 2'h0;
         rd_ptr_ff <= 1'b0;
         wr_ptr_ff <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
         if (push) rd_ptr_ff <= rd_ptr_ff;
         if (push) wr_ptr_ff <= ~wr_ptr_ff;
         if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      end
   end

   // Storage, no reset needed on data
   always_ff @(posedge sys_clk) begin
      if (push) ent_ff[wr_ptr_ff] <= in_data;
   end
endmodule

// ==== logic/halfband_interp.sv ====
// Purpose: Two-times interpolator, midpoint samples between updates
// Assumes: take and half pulses alternate, each one cycle long
// Notes:   Output lags input by one update when enabled
`timescale 1ns/10ps
module halfband_interp (
   input wire logic sys_clk,           // System clock
   input wire logic reset_n,           // Asynchronous reset
   input wire logic enable,            // Filter on, else bypass
   input wire logic take,              // New input sample strobe
   input wire logic half,              // Mid-interval strobe
   input wire logic [15:0] smp_in,     // Signed input sample
   output logic [15:0] smp_out         // Signed converter word
);
   logic [15:0] hold_ff;
   logic [15:0] out_ff;
   logic [16:0] sum;

   // Signed midpoint, one bit wider to avoid overflow
   assign sum = {out_ff[15], out_ff} + {hold_ff[15], hold_ff};
   assign smp_out = out_ff;

   // Bypass passes straight through; enabled runs one update behind
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_ff <= 16'h0000;
         out_ff <= 16'h0000;
      end else if (take) begin
         hold_ff <= smp_in;
         out_ff <= enable ? hold_ff : smp_in;
      end else if (half && enable) begin
         out_ff <= sum[16:1];
      end
   end
endmodule

// ==== verification/waveform_sequencer_dds_asserts.sv ====
// Purpose: Port checks for the waveform sequencer
// Assumes: One clock, reset_n async active low
// Notes:   Bound to the top module below
`timescale 1ns/10ps
module waveform_sequencer_dds_asserts (
   input wire logic sys_clk,          // Clock
   input wire logic reset_n,          // Reset
   input wire logic psel,             // Select
   input wire logic penable,          // Access
   input wire logic [7:0] paddr,      // Address
   input wire logic pready,           // Ready
   input wire logic pslverr,          // Error
   input wire logic [15:0] pattern_out, // Pattern word
   input wire logic pattern_clk,      // Latch clock
   input wire logic marker_out        // Marker
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // ----
   // Bus
   // ----
   sequence access_s; psel && penable; endsequence
   apb_ready_a: assert property (psel |-> pready)
      else $error("pready low");
   bad_addr_a: assert property (access_s |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h34))
      else $error("pslverr wrong for address");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   // ----
   // Pattern and marker
   // ----
   // New word only while the latch clock is low, so the receiver never sees a torn word
   word_launch_a: assert property ($changed(pattern_out) |-> !pattern_clk)
      else $error("word changed with clock high");
   word_hold_a: assert property (pattern_clk |-> $stable(pattern_out))
      else $error("word moved while latched");
   clk_low_a: assert property ($fell(pattern_clk) |-> ##[2:5] $rose(pattern_clk))
      else $error("latch clock stuck low");
   upd_rate_a: assert property ($fell(pattern_clk) |=> (!$fell(pattern_clk)) [*5])
      else $error("update faster than 40 MHz");
   // An update lasts six or seven clocks, so the marker may fall on either
   sequence mark_s; marker_out [*6] ##[1:2] !marker_out; endsequence
   mark_len_a: assert property ($rose(marker_out) |-> mark_s)
      else $error("marker not one update long");
endmodule
bind waveform_sequencer_dds waveform_sequencer_dds_asserts i_waveform_sequencer_dds_asserts (.sys_clk, .reset_n,
   .psel, .penable, .paddr, .pready, .pslverr, .pattern_out, .pattern_clk, .marker_out);

// ==== verification/pattern_receiver.sv ====
// Purpose: Receiver of the digital pattern and marker
// Assumes: Latches on the rising pattern clock
// Notes:   Bench empties the queues before each run
`timescale 1ns/10ps
module pattern_receiver (
   input wire logic pattern_clk,       // Latch clock
   input wire logic [15:0] pattern_out, // Word
   input wire logic [15:0] dac_data,   // Converter word
   input wire logic sync_out,          // Square follower
   input wire logic marker_out         // Marker
);
   logic [15:0] words[$], dacs[$];
   logic marks[$], syncs[$];
   // Capture word and marker together, as a latching receiver would
   always @(posedge pattern_clk) begin
      words.push_back(pattern_out);
      marks.push_back(marker_out);
      dacs.push_back(dac_data);
      syncs.push_back(sync_out);
   end
endmodule

// ==== verification/waveform_sequencer_dds_test.sv ====
// Purpose: Self-checking bench of the waveform sequencer
// Assumes: 250 MHz clock, zero-wait APB
// Notes:   Random segment data from a fixed seed
`timescale 1ns/10ps
`include "wfm_consts.svh"
module waveform_sequencer_dds_test;
   logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, ext_trig = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic pready, pslverr, pattern_clk, marker_out, sync_out;
   logic [15:0] dac_data, pattern_out;
   logic [15:0] wave[512];
   int errors = 0, samples_checked = 0, j;
   always #2 sys_clk = ~sys_clk;
   waveform_sequencer_dds i_waveform_sequencer_dds (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_trig, .dac_data, .pattern_out, .pattern_clk, .marker_out, .sync_out);
   pattern_receiver i_pattern_receiver (.pattern_clk, .pattern_out, .dac_data, .sync_out, .marker_out);
   // ----
   // Tasks
   // ----
   // One APB transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_st(input int b, input logic v);
      do apb(1'b0, `OFF_STATUS, 32'h0); while (rd[b] !== v);
   endtask
   // Empty the receiver before a run
   task automatic flush;
      i_pattern_receiver.words.delete();
      i_pattern_receiver.marks.delete();
      i_pattern_receiver.dacs.delete();
      i_pattern_receiver.syncs.delete();
   endtask
   // Entry 0 plays twice, then entry 1 once
   function automatic logic [15:0] exp_word(input int k);
      return (k < 512) ? wave[k % 256] : wave[k - 256];
   endfunction
   // Held words before a run are skipped; after that no gap is allowed
   task automatic compare_run(input int base, input int n);
      // Buffered words still drain after the state goes quiet
      repeat (40) @(posedge sys_clk);
      j = 0;
      while (j < i_pattern_receiver.words.size() && i_pattern_receiver.words[j] !== exp_word(base)) j++;
      for (int k = 0; k < n; k++) begin
         check("word", i_pattern_receiver.words[j + k], exp_word(base + k));
         check("dac", i_pattern_receiver.dacs[j + k], exp_word(base + k));
         check("marker", i_pattern_receiver.marks[j + k], base + k == 0);
      end
   endtask
   task automatic final_report;
      $display("Checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      void'($urandom(8264));
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      apb(1'b0, 8'h38, 32'h0);
      check("unmapped", rd, 32'h0);
      apb(1'b1, `OFF_WADDR, 32'h0);
      for (int i = 0; i < 512; i++) begin
         wave[i] = 16'($urandom) | 16'h0001;
         apb(1'b1, `OFF_WDATA, {16'h0, wave[i]});
      end
      // Short segment, then index past the table
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `OFF_SEQ_IDX, i ? 32'd290 : 32'd2);
         apb(1'b1, `OFF_SEQ_LEN, i ? 32'd256 : 32'd100);
         apb(1'b1, `OFF_SEQ_LOOP, 32'h1);
         apb(1'b0, `OFF_STATUS, 32'h0);
         check("entry error", rd[2], 1'b1);
         apb(1'b1, `OFF_TRIG, 32'h2);
         apb(1'b0, `OFF_STATUS, 32'h0);
         check("error clear", rd[2], 1'b0);
      end
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `OFF_SEQ_IDX, 32'(i));
         apb(1'b1, `OFF_SEQ_START, 32'(i * 256));
         apb(1'b1, `OFF_SEQ_LEN, 32'd256);
         apb(1'b1, `OFF_SEQ_LOOP, i ? 32'h1 : 32'h1_0002);
      end
      apb(1'b1, `OFF_SEQ_CNT, 32'd2);
      // Single mode, filter off
      apb(1'b1, `OFF_CTRL, 32'h1);
      flush;
      apb(1'b1, `OFF_TRIG, 32'h1);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check("running", rd[0], 1'b1);
      wait_st(0, 1'b0);
      compare_run(0, 768);
      // Stepped mode by external trigger; third step wraps to entry 0
      apb(1'b1, `OFF_CTRL, 32'h9);
      for (int i = 0; i < 3; i++) begin
         flush;
         ext_trig <= 1'b1;
         repeat (2) @(posedge sys_clk);
         ext_trig <= 1'b0;
         wait_st(1, 1'b0);
         wait_st(1, 1'b1);
         compare_run(i == 1 ? 512 : 0, i == 1 ? 256 : 512);
      end
      // Synthesis: half-turn increment alternates lookup entries 0 and 8192, wrapping every second step
      apb(1'b1, `OFF_LDATA, 32'h4000);
      apb(1'b1, `OFF_LADDR, 32'd8192);
      apb(1'b1, `OFF_LDATA, 32'hc000);
      apb(1'b1, `OFF_PHASE_INC, 32'h8000_0000);
      flush;
      apb(1'b1, `OFF_CTRL, 32'h3);
      apb(1'b1, `OFF_TRIG, 32'h1);
      repeat (60) @(posedge sys_clk);
      for (int k = 0; k < 6; k++) begin
         check("lookup word", i_pattern_receiver.words[k], k[0] ? 16'hc000 : 16'h4000);
         check("follower", i_pattern_receiver.syncs[k], !k[0]);
      end
      final_report;
   end
   // Whole run is near 15000 cycles; this allows four times that
   initial begin
      #240000;
      errors++;
      final_report;
   end
endmodule
